// *** common/dfm_defs.vh ***
// Register offsets, field positions, reset values and counts for the DAC format and mute block
`ifndef DFM_DEFS_VH
`define DFM_DEFS_VH

// Control word layout: address in the top seven bits, data in the low nine
`define DFM_WORD_BITS 16
`define DFM_ADDR_MSB 15
`define DFM_ADDR_LSB 9
`define DFM_DATA_MSB 8
`define DFM_DATA_LSB 0

// Register addresses
`define DFM_ADDR_MUTE 7'h02
`define DFM_ADDR_IFACE 7'h03
`define DFM_ADDR_CTRL 7'h09
`define DFM_ADDR_CH4 7'h0F

// Reset values
`define DFM_RST_MUTE 9'h000
`define DFM_RST_IFACE 9'h000
`define DFM_RST_CTRL 9'h000
`define DFM_RST_CH4 9'h000

// Mute register fields
`define DFM_GMUTE_BIT 0
`define DFM_IZD_BIT 4

// Interface control fields
`define DFM_FMT_LSB 0
`define DFM_LRP_BIT 2
`define DFM_BCP_BIT 3
`define DFM_IWL_LSB 4
`define DFM_INV_LSB 6

// Channel mute and zero cross fields
`define DFM_DZC_BIT 0
`define DFM_MUTE_LSB 3

// Fourth channel fields
`define DFM_MUTE4_BIT 2
`define DFM_INV4_BIT 3

// Format codes
`define DFM_FMT_RJ 2'h0
`define DFM_FMT_LJ 2'h1
`define DFM_FMT_I2S 2'h2
`define DFM_FMT_DSP 2'h3

// Word length codes
`define DFM_IWL_16 2'h0
`define DFM_IWL_20 2'h1
`define DFM_IWL_24 2'h2
`define DFM_IWL_32 2'h3

// Counts
`define DFM_ZERO_RUN 11'd1024
`define DFM_DECAY_SHIFT 6
`define DFM_GAIN_FULL 16'hFFFF
`define DFM_AUTO_HALF 6'd16
`define DFM_DSP_WORDS 4'h8

`endif

// *** hdl/dfm_ctl_port.v ***
// Three-wire control port receiver: shifts control words in and latches them on the latch edge
`include "dfm_defs.vh"

module dfm_ctl_port (
    input wire mclk_in,
    input wire rstn_in,
    input wire ctl_clk_in,
    input wire ctl_data_in,
    input wire ctl_latch_in,
    output reg wr_out,
    output reg [6:0] addr_out,
    output reg [8:0] data_out
);

    // Two-stage synchronisers plus one delay stage for edge detection
    reg [2:0] clk_s_q;
    reg [1:0] dat_s_q;
    reg [2:0] lat_s_q;
    // Shift register holding the last sixteen data bits, newest in bit 0
    reg [15:0] shift_q;

    wire clk_rise = clk_s_q[1] & ~clk_s_q[2];
    wire lat_rise = lat_s_q[1] & ~lat_s_q[2];

    // Synchronise pins; only stage two and the delay stage feed logic
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            clk_s_q <= 3'h0;
            dat_s_q <= 2'h0;
            lat_s_q <= 3'h0;
        end else begin
            clk_s_q <= {clk_s_q[1:0], ctl_clk_in};
            dat_s_q <= {dat_s_q[0], ctl_data_in};
            lat_s_q <= {lat_s_q[1:0], ctl_latch_in};
        end
    end

    // Shift on each rising control clock; issue a write on each rising latch
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shift_q <= 16'h0000;
            wr_out <= 1'b0;
            addr_out <= 7'h00;
            data_out <= 9'h000;
        end else begin
            wr_out <= 1'b0;
            if (clk_rise) begin
                shift_q <= {shift_q[14:0], dat_s_q[1]};
            end
            if (lat_rise) begin
                // Upper seven bits address, lower nine bits data
                wr_out <= 1'b1;
                addr_out <= shift_q[`DFM_ADDR_MSB:`DFM_ADDR_LSB];
                data_out <= shift_q[`DFM_DATA_MSB:`DFM_DATA_LSB];
            end
        end
    end

endmodule

// *** hdl/dfm_audio_ctrl.v ***
// Audio serial receiver with format, word length, inversion and mute control for four stereo DACs
`include "dfm_defs.vh"

// Contract
// - Two-bit format select, reset right justified
// - Frame polarity bit inverts expected half levels
// - In DSP, polarity bit picks variant A/B
// - Polarity swap costs one sample between channels
// - Sample on rising bit clock, falling when set
// - Two-bit word length 16/20/24/32, reset 16
// - Thirty-two bit right justified runs 24
// - Signed words zero padded to 24 bits
// - Thirty-two bit words drop eight low bits
// - I2S 24 accepts shorter words, long phases
// - 32 clocks per frame auto selects 16-bit; code does this in I2S only
// - Per-DAC invert bits 8:6 and bit 3
// - Zero cross gates volume update, 1 disables
// - Softmute decays with 64-sample time constant
// - Mute release restarts output at once
// - Analogue mute to midrail, needs zero-detect enable
// - Register mutes only in software mode
// - Channel mute bits 5:3 and bit 2
// - Global mute bit 0 mutes every channel
// - DSP: eight words on line one, fixed order
// - Analogue mute after 1024 zeros or mute
module dfm_audio_ctrl #(
    parameter [10:0] ZERO_RUN = `DFM_ZERO_RUN
) (
    input wire mclk_in,
    input wire rstn_in,
    input wire mode_in,
    input wire ctl_clk_in,
    input wire ctl_data_in,
    input wire ctl_latch_in,
    input wire bclk_in,
    input wire lrclk_in,
    input wire [3:0] serial_data_inputs_in,
    output wire [191:0] sample_out,
    output reg sample_valid_out,
    output wire [3:0] softmute_active_out,
    output wire [3:0] analog_mute_out,
    output wire [7:0] vol_update_ok_out
);

    // Word length in bits for a length code
    function [5:0] dfm_len;
        input [1:0] code;
        begin
            case (code)
                `DFM_IWL_16: dfm_len = 6'd16;
                `DFM_IWL_20: dfm_len = 6'd20;
                `DFM_IWL_24: dfm_len = 6'd24;
                default: dfm_len = 6'd32;
            endcase
        end
    endfunction

    // Align a received word to the 24-bit filter input
    function [23:0] dfm_pad;
        input [31:0] w;
        input [5:0] len;
        begin
            case (len)
                6'd16: dfm_pad = {w[15:0], 8'h00};
                6'd20: dfm_pad = {w[19:0], 4'h0};
                6'd24: dfm_pad = w[23:0];
                default: dfm_pad = w[31:8];
            endcase
        end
    endfunction

    // Two's complement negation; the most negative code saturates
    function [23:0] dfm_neg;
        input [23:0] x;
        begin
            if (x == 24'h800000) begin
                dfm_neg = 24'h7FFFFF;
            end else begin
                dfm_neg = ~x + 24'h000001;
            end
        end
    endfunction

    // Control register file, written only through the serial port
    reg [8:0] mute_q;
    reg [8:0] iface_q;
    reg [8:0] ctrl_q;
    reg [8:0] ch4_q;
    wire ctl_wr;
    wire [6:0] ctl_addr;
    wire [8:0] ctl_data;

    dfm_ctl_port u_ctl (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .ctl_clk_in(ctl_clk_in),
        .ctl_data_in(ctl_data_in),
        .ctl_latch_in(ctl_latch_in),
        .wr_out(ctl_wr),
        .addr_out(ctl_addr),
        .data_out(ctl_data)
    );

    // Register writes; unknown addresses are ignored
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mute_q <= `DFM_RST_MUTE;
            iface_q <= `DFM_RST_IFACE;
            ctrl_q <= `DFM_RST_CTRL;
            ch4_q <= `DFM_RST_CH4;
        end else if (ctl_wr) begin
            case (ctl_addr)
                `DFM_ADDR_MUTE: mute_q <= ctl_data;
                `DFM_ADDR_IFACE: iface_q <= ctl_data;
                `DFM_ADDR_CTRL: ctrl_q <= ctl_data;
                `DFM_ADDR_CH4: ch4_q <= ctl_data;
                default: ;
            endcase
        end
    end

    // Decoded fields
    wire [1:0] fmt = iface_q[`DFM_FMT_LSB+1:`DFM_FMT_LSB];
    wire frame_clock_polarity = iface_q[`DFM_LRP_BIT];
    wire bit_clock_polarity = iface_q[`DFM_BCP_BIT];
    wire [1:0] word_length_select = iface_q[`DFM_IWL_LSB+1:`DFM_IWL_LSB];
    wire [3:0] inv = {ch4_q[`DFM_INV4_BIT], iface_q[`DFM_INV_LSB+2:`DFM_INV_LSB]};
    wire dzc_off = ctrl_q[`DFM_DZC_BIT];
    wire [3:0] cmute = {ch4_q[`DFM_MUTE4_BIT], ctrl_q[`DFM_MUTE_LSB+2:`DFM_MUTE_LSB]};
    wire gmute = mute_q[`DFM_GMUTE_BIT];
    wire zero_detect_analog_mute = mute_q[`DFM_IZD_BIT];
    wire is_dsp = (fmt == `DFM_FMT_DSP);

    // Pin synchronisers; stage one feeds only stage two
    reg [2:0] bclk_s_q;
    reg [1:0] lr_s_q;
    reg [3:0] din_s1_q;
    reg [3:0] din_s2_q;
    reg [1:0] mode_s_q;

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bclk_s_q <= 3'h0;
            lr_s_q <= 2'h0;
            din_s1_q <= 4'h0;
            din_s2_q <= 4'h0;
            mode_s_q <= 2'h0;
        end else begin
            bclk_s_q <= {bclk_s_q[1:0], bclk_in};
            lr_s_q <= {lr_s_q[0], lrclk_in};
            din_s1_q <= serial_data_inputs_in;
            din_s2_q <= din_s1_q;
            mode_s_q <= {mode_s_q[0], mode_in};
        end
    end

    // Software control mode when the mode pin is low
    wire swmode = ~mode_s_q[1];
    wire lr_now = lr_s_q[1];
    wire [3:0] din_now = din_s2_q;
    // Edge choice relies on the source changing on the other edge
    wire samp_edge = bit_clock_polarity ? (bclk_s_q[2] & ~bclk_s_q[1]) : (bclk_s_q[1] & ~bclk_s_q[2]);

    // Receiver state
    reg lr_prev_q;
    reg [5:0] cnt_q;
    reg [5:0] hlen_q;
    reg auto_q;
    reg [5:0] wb_q;
    reg [3:0] wi_q;
    reg commit_q;
    reg [31:0] sh_q [0:3];
    reg [23:0] samp_q [0:7];
    integer i;

    // Effective word length after format overrides
    wire auto16 = (fmt == `DFM_FMT_I2S) && auto_q;
    wire rj32 = (fmt == `DFM_FMT_RJ) && (word_length_select == `DFM_IWL_32);
    wire [5:0] len = auto16 ? 6'd16 : (rj32 ? 6'd24 : dfm_len(word_length_select));

    // Bits counted in the current frame half, including this one
    wire trans = lr_now ^ lr_prev_q;
    wire [5:0] cnt_inc = (cnt_q == 6'd63) ? cnt_q : cnt_q + 6'd1;
    wire [5:0] cnt_n = trans ? 6'd1 : cnt_inc;

    // Frame level that marks the left half; I2S is the inverse of the justified formats
    wire left_lvl = (fmt != `DFM_FMT_I2S) ^ frame_clock_polarity;

    // Stereo capture decision per format
    reg cap_st;
    reg cap_right;
    reg cap_old;
    always @* begin
        cap_st = 1'b0;
        cap_right = 1'b0;
        cap_old = 1'b0;
        case (fmt)
            `DFM_FMT_RJ: begin
                // Last bit before the frame edge ends the word
                cap_st = trans;
                cap_right = (lr_prev_q != left_lvl);
                cap_old = 1'b1;
            end
            `DFM_FMT_LJ: begin
                cap_st = (cnt_n == len);
                cap_right = (lr_now != left_lvl);
            end
            `DFM_FMT_I2S: begin
                // One bit of delay after the frame edge; shorter words just read as zero tail
                cap_st = (cnt_n == len + 6'd1);
                cap_right = (lr_now != left_lvl);
            end
            default: ;
        endcase
    end

    // DSP framing: rising frame edge restarts the word sequence
    wire rise = lr_now & ~lr_prev_q;
    wire [5:0] wb_inc = (wb_q == 6'd63) ? wb_q : wb_q + 6'd1;
    // Variant B has the first bit on the edge itself, variant A one edge later
    wire [5:0] wb_n = rise ? {5'h00, frame_clock_polarity} : wb_inc;
    wire [3:0] wi_eff = rise ? 4'h0 : wi_q;
    wire cap_dsp = (wi_eff < `DFM_DSP_WORDS) && (wb_n == len);
    wire [31:0] dsp_word = {sh_q[0][30:0], din_now[0]};

    // Receiver: shift, count and capture on each sampling edge
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lr_prev_q <= 1'b0;
            cnt_q <= 6'h00;
            hlen_q <= 6'h00;
            auto_q <= 1'b0;
            wb_q <= 6'h00;
            wi_q <= `DFM_DSP_WORDS;
            commit_q <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                sh_q[i] <= 32'h00000000;
            end
            for (i = 0; i < 8; i = i + 1) begin
                samp_q[i] <= 24'h000000;
            end
        end else begin
            commit_q <= 1'b0;
            if (samp_edge) begin
                lr_prev_q <= lr_now;
                cnt_q <= cnt_n;
                wb_q <= cap_dsp ? 6'h00 : wb_n;
                wi_q <= cap_dsp ? wi_eff + 4'h1 : wi_eff;
                if (trans) begin
                    // Two halves of exactly sixteen clocks each mean a 16-bit source
                    hlen_q <= cnt_q;
                    auto_q <= (cnt_q == `DFM_AUTO_HALF) && (hlen_q == `DFM_AUTO_HALF);
                end
                for (i = 0; i < 4; i = i + 1) begin
                    sh_q[i] <= {sh_q[i][30:0], din_now[i]};
                end
                if (is_dsp) begin
                    if (cap_dsp) begin
                        // Words arrive left then right, DAC one to four, on line one only
                        samp_q[wi_eff[2:0]] <= dfm_pad(dsp_word, len);
                        if (wi_eff == 4'h7) begin
                            commit_q <= 1'b1;
                        end
                    end
                end else if (cap_st) begin
                    for (i = 0; i < 4; i = i + 1) begin
                        if (cap_old) begin
                            samp_q[2*i+cap_right] <= dfm_pad(sh_q[i], len);
                        end else begin
                            samp_q[2*i+cap_right] <= dfm_pad({sh_q[i][30:0], din_now[i]}, len);
                        end
                    end
                    // A pair commits on its right word; swapped halves land a sample apart
                    if (cap_right) begin
                        commit_q <= 1'b1;
                    end
                end
            end
        end
    end

    // Per-DAC mute state, softmute gain and zero run counters
    reg [15:0] gain_q [0:3];
    reg [10:0] zcnt_q [0:3];
    reg [3:0] smute_q;
    reg [3:0] amute_q;
    reg [3:0] muted;
    integer m;

    // Mute request is live as soon as the register changes
    always @* begin
        for (m = 0; m < 4; m = m + 1) begin
            muted[m] = swmode & (cmute[m] | gmute);
        end
    end

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            smute_q <= 4'h0;
            amute_q <= 4'h0;
            for (m = 0; m < 4; m = m + 1) begin
                gain_q[m] <= `DFM_GAIN_FULL;
                zcnt_q[m] <= 11'h000;
            end
        end else begin
            smute_q <= muted;
            for (m = 0; m < 4; m = m + 1) begin
                if (!muted[m]) begin
                    // No ramp back: full gain on the very next sample
                    gain_q[m] <= `DFM_GAIN_FULL;
                end else if (commit_q) begin
                    // Each sample loses 1/64 of the gain: exponential decay to midrail
                    gain_q[m] <= gain_q[m] - (gain_q[m] >> `DFM_DECAY_SHIFT);
                end
                if (commit_q) begin
                    if (samp_q[2*m] == 24'h000000 && samp_q[2*m+1] == 24'h000000) begin
                        if (zcnt_q[m] != ZERO_RUN) begin
                            zcnt_q[m] <= zcnt_q[m] + 11'h001;
                        end
                    end else begin
                        zcnt_q[m] <= 11'h000;
                    end
                end
                // Clamp to midrail on a long zero run or a register mute
                amute_q[m] <= swmode & zero_detect_analog_mute & ((zcnt_q[m] == ZERO_RUN) | muted[m]);
            end
        end
    end

    // Valid strobe follows each committed sample set
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sample_valid_out <= 1'b0;
        end else begin
            sample_valid_out <= commit_q;
        end
    end

    assign softmute_active_out = smute_q;
    assign analog_mute_out = amute_q;

    // Output stage per channel: scale by gain, invert, flag zero crossings
    genvar c;
    generate
        for (c = 0; c < 8; c = c + 1) begin : g_ch
            wire [40:0] prod = $signed(samp_q[c]) * $signed({1'b0, gain_q[c/2]});
            // Bypass at full gain so unmuted data passes bit exact
            wire [23:0] scaled = (gain_q[c/2] == `DFM_GAIN_FULL) ? samp_q[c] : prod[39:16];
            wire [23:0] shaped = inv[c/2] ? dfm_neg(scaled) : scaled;
            reg [23:0] out_q;
            reg ok_q;
            always @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    out_q <= 24'h000000;
                    ok_q <= 1'b0;
                end else begin
                    ok_q <= 1'b0;
                    if (commit_q) begin
                        out_q <= shaped;
                        // Volume may change on a sign change or zero, or freely when disabled
                        ok_q <= dzc_off | (shaped == 24'h000000) | (shaped[23] != out_q[23]);
                    end
                end
            end
            assign sample_out[c*24+23:c*24] = out_q;
            assign vol_update_ok_out[c] = ok_q;
        end
    endgenerate

endmodule

// *** sim/dfm_audio_chk.sv ***
// Port checker for the DAC format and mute block
module dfm_audio_chk #(
    parameter [10:0] ZERO_RUN = 11'h400
) (
    input wire mclk_in,
    input wire rstn_in,
    input wire mode_in,
    input wire ctl_latch_in,
    input wire [191:0] sample_out,
    input wire sample_valid_out,
    input wire [3:0] softmute_active_out,
    input wire [3:0] analog_mute_out,
    input wire [7:0] vol_update_ok_out
);
    reg [3:0] quiet_q; // Cycles since latch or mode pin moved
    reg [1:0] pin_q; // Last seen latch and mode levels

    // Softmute state may only move shortly after a control latch or mode change
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            quiet_q <= 4'h0;
            pin_q <= 2'h0;
        end else begin
            pin_q <= {ctl_latch_in, mode_in};
            if (pin_q != {ctl_latch_in, mode_in}) begin
                quiet_q <= 4'h0;
            end else if (quiet_q != 4'hF) begin
                quiet_q <= quiet_q + 4'h1;
            end
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    valid_pulse_a: assert property (sample_valid_out |=> !sample_valid_out [*8])
        else $error("sample strobe repeated too soon");
    sample_hold_a: assert property (!sample_valid_out |-> $stable(sample_out))
        else $error("samples moved without strobe");
    vok_strobe_a: assert property (|vol_update_ok_out |-> sample_valid_out)
        else $error("volume strobe without sample");
    zc_first_a: assert property (sample_valid_out && sample_out[23:0] == 24'h0
        |-> vol_update_ok_out[0]) else $error("zero sample gave no volume strobe");
    zc_last_a: assert property (sample_valid_out && sample_out[191:168] == 24'h0
        |-> vol_update_ok_out[7]) else $error("zero sample gave no volume strobe");
    hw_soft_a: assert property (mode_in [*5] |-> softmute_active_out == 4'h0)
        else $error("softmute active in hardware mode");
    hw_analog_a: assert property (mode_in [*7] |-> analog_mute_out == 4'h0)
        else $error("analogue mute active in hardware mode");
    mute_cause_a: assert property ($changed(softmute_active_out) |-> quiet_q < 4'hA)
        else $error("softmute moved without a write");

    cover property (sample_valid_out);
    cover property ($rose(softmute_active_out[0]));
    cover property ($rose(analog_mute_out[3]));
endmodule

bind dfm_audio_ctrl dfm_audio_chk #(.ZERO_RUN(ZERO_RUN)) chk (.mclk_in(mclk_in),
    .rstn_in(rstn_in), .mode_in(mode_in), .ctl_latch_in(ctl_latch_in),
    .sample_out(sample_out), .sample_valid_out(sample_valid_out),
    .softmute_active_out(softmute_active_out), .analog_mute_out(analog_mute_out),
    .vol_update_ok_out(vol_update_ok_out));

// *** sim/dfm_src_model.sv ***
// Audio source model: bit clock, frame clock and four data lines
module dfm_src_model (
    output logic bclk_out = 1'b0,
    output logic lrclk_out = 1'b0,
    output logic [3:0] din_out = 4'h0
);
    timeunit 1ns;
    timeprecision 1ns;

    // One bit: change on the non-sampling edge, hold over the sampling edge
    task automatic put(input logic bit_clock_polarity, input logic lr, input logic [3:0] d);
        bclk_out = bit_clock_polarity;
        lrclk_out = lr;
        din_out = d;
        #400;
        bclk_out = ~bit_clock_polarity;
        #400;
    endtask

    // One frame; unused slots carry the inverse of the last level
    task automatic send(input logic [1:0] fmt, input logic frame_clock_polarity, input logic bit_clock_polarity,
                        input int n, input logic [31:0] w [8]);
        int p;
        int k;
        int idx;
        logic lv;
        logic [3:0] d;
        #17;
        if (fmt == 2'h3) begin
            put(bit_clock_polarity, 1'b0, ~din_out);
            put(bit_clock_polarity, ~frame_clock_polarity, ~din_out);
            for (p = 0; p < 8 * n; p++) begin
                d = ~din_out;
                d[0] = w[p / n][n - 1 - p % n];
                put(bit_clock_polarity, frame_clock_polarity && p == 0, d);
            end
            put(bit_clock_polarity, 1'b0, ~din_out);
        end else begin
            lv = (fmt != 2'h2) ^ frame_clock_polarity;
            put(bit_clock_polarity, ~lv, ~din_out);
            for (p = 0; p < 64; p++) begin
                idx = fmt == 2'h1 ? p % 32 : (fmt == 2'h2 ? p % 32 - 1 : p % 32 - 32 + n);
                d = ~din_out;
                for (k = 0; k < 4; k++) begin
                    if (idx >= 0 && idx < n) d[k] = w[2 * k + p / 32][n - 1 - idx];
                end
                put(bit_clock_polarity, p < 32 ? lv : ~lv, d);
            end
            // Trailing edge closes a right justified frame
            put(bit_clock_polarity, lv, ~din_out);
        end
        #400;
        bclk_out = bit_clock_polarity; // Clock stands still between frames
        din_out = ~din_out;
    endtask
endmodule

// *** sim/tb.sv ***
// Testbench for the DAC format and mute block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] fmt;
        logic frame_clock_polarity;
        logic bit_clock_polarity;
        logic [1:0] word_length_select;
        logic [5:0] n;
        logic [31:0] base;
    } dfm_row_t;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic mode_in = 1'b0;
    logic ctl_clk_in = 1'b0;
    logic ctl_data_in = 1'b0;
    logic ctl_latch_in = 1'b0;
    logic bclk_in;
    logic lrclk_in;
    logic [3:0] din;
    logic [191:0] sample_out;
    logic sample_valid_out;
    logic [3:0] softmute_active_out;
    logic [3:0] analog_mute_out;
    logic [7:0] vol_update_ok_out;
    logic [7:0] vok_q; // Volume strobes seen with the last sample
    logic [31:0] w [8];
    logic [31:0] z [8] = '{default: 32'h0};
    int err_total = 0;
    int n_tests = 0;
    int i;
    // Format rows; n is the word length the block should settle on
    dfm_row_t rows [9] = '{'{2'h0, 1'b0, 1'b0, 2'h0, 6'h10, 32'h12345678},
        '{2'h1, 1'b0, 1'b0, 2'h1, 6'h14, 32'h0A5C3E71}, '{2'h2, 1'b0, 1'b0, 2'h2, 6'h18, 32'h00F0E1D2},
        '{2'h1, 1'b1, 1'b1, 2'h3, 6'h20, 32'h3C2B1A09}, '{2'h0, 1'b0, 1'b0, 2'h3, 6'h18, 32'h00654321},
        '{2'h2, 1'b1, 1'b0, 2'h0, 6'h10, 32'h00002468}, '{2'h0, 1'b1, 1'b1, 2'h2, 6'h18, 32'h00135790},
        '{2'h3, 1'b0, 1'b0, 2'h0, 6'h10, 32'h0000ACE1}, '{2'h3, 1'b1, 1'b1, 2'h2, 6'h18, 32'h0077AA55}};
    // Mute writes: address, data, softmute state expected after it
    logic [19:0] mt [8] = '{{7'h09, 9'h008, 4'h1}, {7'h09, 9'h030, 4'h6}, {7'h0F, 9'h004, 4'hE},
        {7'h09, 9'h000, 4'h8}, {7'h0F, 9'h000, 4'h0}, {7'h02, 9'h001, 4'hF},
        {7'h02, 9'h000, 4'h0}, {7'h05, 9'h001, 4'h0}};

    dfm_src_model src (.bclk_out(bclk_in), .lrclk_out(lrclk_in), .din_out(din));
    dfm_audio_ctrl #(.ZERO_RUN(11'h004)) uut (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .mode_in(mode_in), .ctl_clk_in(ctl_clk_in), .ctl_data_in(ctl_data_in),
        .ctl_latch_in(ctl_latch_in), .bclk_in(bclk_in), .lrclk_in(lrclk_in),
        .serial_data_inputs_in(din), .sample_out(sample_out),
        .sample_valid_out(sample_valid_out), .softmute_active_out(softmute_active_out),
        .analog_mute_out(analog_mute_out), .vol_update_ok_out(vol_update_ok_out));

    // 10 MHz system clock
    initial begin
        forever #50 mclk_in = ~mclk_in;
    end

    // Keep the volume strobes that came with the latest sample
    always @(posedge mclk_in) begin
        if (sample_valid_out === 1'b1) vok_q <= vol_update_ok_out;
    end

    // Word as the filters should see it
    function automatic logic [23:0] pad(input int n, input logic [31:0] v);
        case (n)
            16: pad = {v[15:0], 8'h00};
            20: pad = {v[19:0], 4'h0};
            24: pad = v[23:0];
            default: pad = v[31:8];
        endcase
    endfunction

    task automatic chk(input logic [191:0] got, input logic [191:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Control word, MSB first, each control clock level held four system clocks
    task automatic wr(input logic [6:0] a, input logic [8:0] v);
        logic [15:0] s;
        int b;
        s = {a, v};
        for (b = 15; b >= 0; b--) begin
            ctl_clk_in = 1'b0;
            ctl_data_in = s[b];
            repeat (4) @(negedge mclk_in);
            ctl_clk_in = 1'b1;
            repeat (4) @(negedge mclk_in);
        end
        ctl_latch_in = 1'b1;
        repeat (4) @(negedge mclk_in);
        ctl_latch_in = 1'b0;
        repeat (8) @(negedge mclk_in);
    endtask

    // Send one frame and compare all eight channels; neg marks inverted ones
    task automatic run(input logic [1:0] fmt, input logic frame_clock_polarity, input logic bit_clock_polarity, input int n,
                       input logic [31:0] base, input logic [7:0] neg);
        logic [191:0] e;
        int c;
        for (c = 0; c < 8; c++) begin
            w[c] = base + c * 32'h01111111;
            e[24 * c +: 24] = neg[c] ? -pad(n, w[c]) : pad(n, w[c]);
        end
        src.send(fmt, frame_clock_polarity, bit_clock_polarity, n, w);
        repeat (8) @(negedge mclk_in);
        chk(sample_out, e);
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of about 1.6 ms
    initial begin
        #8000000;
        err_total++;
        finish_test();
    end

    initial begin
        repeat (8) @(negedge mclk_in);
        rstn_in = 1'b1;
        for (i = 0; i < 9; i++) begin
            wr(7'h03, {3'h0, rows[i].word_length_select, rows[i].bit_clock_polarity, rows[i].frame_clock_polarity, rows[i].fmt});
            run(rows[i].fmt, rows[i].frame_clock_polarity, rows[i].bit_clock_polarity, rows[i].n, rows[i].base, 8'h00);
        end
        // Reset in mid-run brings back right justified 16-bit
        rstn_in = 1'b0;
        repeat (8) @(negedge mclk_in);
        chk(sample_out, 192'h0);
        rstn_in = 1'b1;
        run(2'h0, 1'b0, 1'b0, 16, 32'h00ABCDEF, 8'h00);
        wr(7'h03, 9'h161);
        wr(7'h0F, 9'h008);
        run(2'h1, 1'b0, 1'b0, 24, 32'h00054321, 8'hF3);
        wr(7'h0F, 9'h000);
        wr(7'h03, 9'h021);
        wr(7'h09, 9'h001);
        run(2'h1, 1'b0, 1'b0, 24, 32'h00012345, 8'h00);
        chk({184'h0, vok_q}, {184'h0, 8'hFF});
        wr(7'h09, 9'h000);
        run(2'h1, 1'b0, 1'b0, 24, 32'h00012345, 8'h00);
        chk({184'h0, vok_q}, 192'h0);
        for (i = 0; i < 8; i++) begin
            wr(mt[i][19:13], mt[i][12:4]);
            chk({188'h0, softmute_active_out}, {188'h0, mt[i][3:0]});
        end
        // Muted channel decays by about one part in 64 per sample
        wr(7'h09, 9'h008);
        run(2'h1, 1'b0, 1'b0, 24, 32'h00012345, 8'h00);
        src.send(2'h1, 1'b0, 1'b0, 24, w);
        repeat (8) @(negedge mclk_in);
        n_tests++;
        if ($isunknown(sample_out[23:0]) || sample_out[23:0] >= w[0][23:0] ||
            sample_out[23:0] < w[0][23:0] - w[0][23:0] / 32) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, sample_out[23:0], w[0][23:0]);
        end
        wr(7'h09, 9'h000);
        run(2'h1, 1'b0, 1'b0, 24, 32'h00012345, 8'h00);
        wr(7'h02, 9'h010);
        wr(7'h09, 9'h008);
        chk({188'h0, analog_mute_out}, {188'h0, 4'h1});
        wr(7'h09, 9'h000);
        for (i = 0; i < 4; i++) begin
            src.send(2'h1, 1'b0, 1'b0, 24, z);
            repeat (8) @(negedge mclk_in);
            chk({188'h0, analog_mute_out}, {188'h0, (i == 3 ? 4'hF : 4'h0)});
        end
        wr(7'h02, 9'h011);
        chk({184'h0, analog_mute_out, softmute_active_out}, {184'h0, 8'hFF});
        mode_in = 1'b1;
        repeat (8) @(negedge mclk_in);
        chk({184'h0, analog_mute_out, softmute_active_out}, 192'h0);
        finish_test();
    end
endmodule
